// [src/fio_supervisor.sv]
// Fill I/O supervisor: maps machine I/O and sequences one fill cycle.
// Assumes weight and stable flags are synchronous to clk; port pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module fio_supervisor
    import fio_pkg::*;
#(
    parameter int SETTLE_CYC = FIO_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [FIO_IN_W-1:0] pin_in,
    output logic [FIO_OUT_W-1:0] pin_out,
    input wire fio_wts_t wts,
    input wire logic scale_stable,
    input wire fio_cfg_t cfg,
    input wire logic [FIO_SEL_IN_N*3-1:0] sel_in_fn,
    input wire logic [FIO_SEL_OUT_N*3-1:0] sel_out_fn,
    output logic preact_strobe,
    output logic report_strobe
);
    logic [FIO_IN_W-1:0] sync_a, sync_b, db_in;
    logic [FIO_IN_W-1:0] next_db_in;
    logic [FIO_IN_W-1:0][FIO_DB_W-1:0] db_cnt, next_db_cnt;
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    for (genvar i = 0; i < FIO_IN_W; i++) begin : g_db
        always_comb begin
            next_db_in[i] = db_in[i];
            next_db_cnt[i] = '0;
            if (sync_b[i] != db_in[i]) begin
                next_db_cnt[i] = db_cnt[i] + 1'b1;
                if (db_cnt[i] == FIO_DB_W'(FIO_DEBOUNCE_CYC - 1)) begin
                    next_db_in[i] = sync_b[i];
                    next_db_cnt[i] = '0;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            db_in <= '0;
            db_cnt <= '0;
        end else begin
            db_in <= next_db_in;
            db_cnt <= next_db_cnt;
        end
    end

    logic in_start, in_up, in_down, in_rst;
    function automatic logic pick_in(input logic [FIO_IN_W-1:0] v, input int pos);
        logic r;
        r = v[pos];
        if (cfg.in_res_route && cfg.in_res_fail[0] && sel_in_fn[2:0] == FIO_FN_RESERVE) begin
            if (pos == FIO_IN_START) r = v[FIO_IN_RES1];
        end
        if (cfg.in_res_route && cfg.in_res_fail[1] && sel_in_fn[5:3] == FIO_FN_RESERVE) begin
            if (pos == FIO_IN_VALVE_DOWN) r = v[FIO_IN_RES2];
        end
        return r;
    endfunction
    always_comb begin
        in_start = pick_in(db_in, FIO_IN_START);
        in_up = db_in[FIO_IN_VALVE_UP];
        in_down = pick_in(db_in, FIO_IN_VALVE_DOWN);
        in_rst = db_in[FIO_IN_RESET];
    end

    // selectable input functions, disabled code ignores the port
    logic [FIO_SEL_IN_N-1:0] has_run, run_ok, inh_on, int_on, res_on;
    for (genvar i = 0; i < FIO_SEL_IN_N; i++) begin : g_sel_in
        logic [2:0] fn;
        assign fn = sel_in_fn[i*3 +: 3];
        assign has_run[i] = (fn == FIO_FN_RUN_EN);
        assign run_ok[i] = (fn == FIO_FN_RUN_EN) && db_in[i + FIO_IN_RES1];
        assign inh_on[i] = (fn == FIO_FN_INHIBIT) && db_in[i + FIO_IN_RES1];
        assign res_on[i] = (fn == FIO_FN_RESUME) && db_in[i + FIO_IN_RES1];
        assign int_on[i] = (fn == FIO_FN_INTERRUPT) && !db_in[i + FIO_IN_RES1];
    end
    logic run_enable, inhibit, interrupt, resume;
    assign run_enable = (has_run == '0) || (run_ok != '0);
    assign inhibit = inh_on != '0;
    assign interrupt = int_on != '0;
    assign resume = res_on != '0;

    // Sequencer
    fio_state_t state, next_state;
    logic [1:0] stage, next_stage;
    logic err, next_err, done, next_done, tripped, next_tripped;
    logic [FIO_SET_W-1:0] settle, next_settle;
    logic next_preact, next_report;
    logic tare_ok;
    assign tare_ok = (wts.weight > wts.tare_min) && (wts.weight < wts.tare_max) && scale_stable;

    always_comb begin
        next_state = state;
        next_stage = stage;
        next_err = err;
        next_done = done;
        next_tripped = tripped;
        next_settle = settle;
        next_preact = 1'b0;
        next_report = 1'b0;
        case (state)
            FIO_IDLE: begin
                if (in_start && run_enable && !inhibit) begin
                    next_state = FIO_TARE;
                    next_err = 1'b0;
                    next_done = 1'b0;
                    next_tripped = 1'b0;
                end
            end
            FIO_TARE: begin
                if (tare_ok) begin
                    next_state = FIO_LOWER;
                end else if (scale_stable) begin
                    next_err = 1'b1;
                    next_state = FIO_UNLOAD;
                end
            end
            FIO_LOWER: begin
                if (wts.weight > wts.valve_force) begin
                    next_state = FIO_RAISE;
                    next_tripped = 1'b1;
                    next_err = 1'b1;
                end else if (in_down) begin
                    next_state = FIO_FEED;
                    // optional fine or medium start stage
                    next_stage = cfg.first_speed;
                end
            end
            FIO_FEED: begin
                if (!interrupt) begin
                    if (stage == 2'd0 && wts.weight >= wts.cut_coarse) begin
                        next_stage = (cfg.speeds == 2'd3) ? 2'd1 : 2'd2;
                    end else if (stage == 2'd1 && wts.weight >= wts.cut_medium) begin
                        next_stage = 2'd2;
                    end else if (wts.weight >= wts.target) begin
                        next_state = FIO_RAISE;
                    end
                end
            end
            FIO_RAISE: begin
                if (in_up) begin
                    next_state = tripped ? FIO_FAULT : FIO_SETTLE;
                    next_settle = '0;
                end
            end
            FIO_SETTLE: begin
                if (settle < FIO_SET_W'(SETTLE_CYC - 1)) begin
                    next_settle = settle + 1'b1;
                end else if (scale_stable) begin
                    next_preact = cfg.preact_auto;
                    next_state = FIO_REPORT;
                end
            end
            FIO_REPORT: begin
                if (scale_stable) begin
                    next_report = cfg.report_en;
                    next_done = 1'b1;
                    next_state = FIO_UNLOAD;
                end
            end
            FIO_UNLOAD: begin
                if (!in_start) begin
                    next_state = FIO_IDLE;
                end
            end
            FIO_FAULT: begin
                if (resume) begin
                    next_state = FIO_UNLOAD;
                end
            end
            default: next_state = FIO_IDLE;
        endcase
        if (in_rst) begin
            next_state = FIO_IDLE;
            next_err = 1'b0;
            next_done = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= FIO_IDLE;
            stage <= 2'd0;
            err <= 1'b0;
            done <= 1'b0;
            tripped <= 1'b0;
            settle <= '0;
            preact_strobe <= 1'b0;
            report_strobe <= 1'b0;
        end else begin
            state <= next_state;
            stage <= next_stage;
            err <= next_err;
            done <= next_done;
            tripped <= next_tripped;
            settle <= next_settle;
            preact_strobe <= next_preact;
            report_strobe <= next_report;
        end
    end

    logic [FIO_OUT_W-1:0] next_out;
    always_comb begin
        logic feeding;
        feeding = (state == FIO_FEED) && !interrupt;
        next_out = '0;
        next_out[FIO_OUT_READY] = (state == FIO_IDLE) && run_enable;
        next_out[FIO_OUT_COARSE] = feeding && stage == 2'd0;
        next_out[FIO_OUT_MEDIUM] = feeding && stage == 2'd1;
        next_out[FIO_OUT_FINE] = feeding && stage == 2'd2;
        next_out[FIO_OUT_VALVE] = (state == FIO_LOWER) || (state == FIO_FEED);
        next_out[FIO_OUT_CATCH] = !((state == FIO_LOWER) || (state == FIO_FEED));
        next_out[FIO_OUT_DONE] = done;
        next_out[FIO_OUT_ERROR] = err;
        for (int i = 0; i < FIO_SEL_OUT_N; i++) begin
            if (sel_out_fn[i*3 +: 3] == FIO_FN_BUSY) next_out[FIO_OUT_RES1 + i] = state != FIO_IDLE;
            if (sel_out_fn[i*3 +: 3] == FIO_FN_FILL_ERR) next_out[FIO_OUT_RES1 + i] = err;
        end
        if (cfg.out_res_route && cfg.out_res_fail[0] && sel_out_fn[2:0] == FIO_FN_RESERVE) begin
            next_out[FIO_OUT_RES1] = next_out[FIO_OUT_VALVE];
        end
        if (cfg.out_res_route && cfg.out_res_fail[1] && sel_out_fn[5:3] == FIO_FN_RESERVE) begin
            next_out[FIO_OUT_RES2] = next_out[FIO_OUT_ERROR];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_out <= '0;
        end else begin
            pin_out <= next_out;
        end
    end
endmodule : fio_supervisor
`default_nettype wire

// [include/fio_pkg.sv]
// Package for the fill I/O supervisor: port maps, weight fields, timing counts.
// Assumes a 100 MHz clock; weights arrive as unsigned words from the weighing front end.
package fio_pkg;
    localparam int FIO_IN_W = 16;
    localparam int FIO_OUT_W = 16;
    localparam int FIO_WT_W = 24;
    // Fixed input bit positions (input n sits at bit n-1)
    localparam int FIO_IN_START = 0;
    localparam int FIO_IN_VALVE_UP = 1;
    localparam int FIO_IN_VALVE_DOWN = 4;
    localparam int FIO_IN_RESET = 5;
    localparam int FIO_IN_RES1 = 6;
    localparam int FIO_IN_RES2 = 7;
    // Fixed output bit positions
    localparam int FIO_OUT_READY = 0;
    localparam int FIO_OUT_COARSE = 1;
    localparam int FIO_OUT_MEDIUM = 2;
    localparam int FIO_OUT_FINE = 3;
    localparam int FIO_OUT_VALVE = 4;
    localparam int FIO_OUT_CATCH = 7;
    localparam int FIO_OUT_DONE = 8;
    localparam int FIO_OUT_ERROR = 9;
    localparam int FIO_OUT_RES1 = 10;
    localparam int FIO_OUT_RES2 = 11;
    // Selectable function codes for inputs 7..16 and outputs 11..16
    localparam logic [2:0] FIO_FN_OFF = 3'h0;
    localparam logic [2:0] FIO_FN_RUN_EN = 3'h1;
    localparam logic [2:0] FIO_FN_INHIBIT = 3'h2;
    localparam logic [2:0] FIO_FN_INTERRUPT = 3'h3;
    localparam logic [2:0] FIO_FN_RESUME = 3'h4;
    localparam logic [2:0] FIO_FN_RESERVE = 3'h5;
    localparam logic [2:0] FIO_FN_BUSY = 3'h1;
    localparam logic [2:0] FIO_FN_FILL_ERR = 3'h2;
    localparam int FIO_SEL_IN_N = 10;
    localparam int FIO_SEL_OUT_N = 6;
    // Timing
    localparam int FIO_CLK_MHZ = 100;
    localparam int FIO_DEBOUNCE_US = 10;
    localparam int FIO_DEBOUNCE_CYC = FIO_DEBOUNCE_US * FIO_CLK_MHZ;
    localparam int FIO_DB_W = 10;
    localparam int FIO_SETTLE_MS = 500;
    localparam int FIO_SETTLE_CYC = FIO_SETTLE_MS * 1000 * FIO_CLK_MHZ;
    localparam int FIO_SET_W = 26;

    typedef struct packed {
        logic [FIO_WT_W-1:0] weight;
        logic [FIO_WT_W-1:0] tare_min;
        logic [FIO_WT_W-1:0] tare_max;
        logic [FIO_WT_W-1:0] valve_force;
        logic [FIO_WT_W-1:0] cut_coarse;
        logic [FIO_WT_W-1:0] cut_medium;
        logic [FIO_WT_W-1:0] target;
    } fio_wts_t;

    typedef struct packed {
        logic [1:0] speeds;
        logic [1:0] first_speed;
        logic preact_auto;
        logic report_en;
        logic in_res_route;
        logic out_res_route;
        logic [1:0] in_res_fail;
        logic [1:0] out_res_fail;
    } fio_cfg_t;

    typedef enum logic [8:0] {
        FIO_IDLE = 9'h001,
        FIO_TARE = 9'h002,
        FIO_LOWER = 9'h004,
        FIO_FEED = 9'h008,
        FIO_RAISE = 9'h010,
        FIO_SETTLE = 9'h020,
        FIO_REPORT = 9'h040,
        FIO_UNLOAD = 9'h080,
        FIO_FAULT = 9'h100
    } fio_state_t;
endpackage : fio_pkg

// [testbench/fio_machine.sv]
// Valve model with up and down position switches.
// Assumes the valve command is output 5 and the switches feed inputs 2 and 8.
`timescale 1ns/10ps
`default_nettype none
module fio_machine #(
    parameter int TRAVEL = 40
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic valve_cmd,
    input wire logic jam,
    output logic valve_up,
    output logic valve_down
);
    int cnt;
    logic last;
    always_ff @(posedge clk) begin
        if (reset || valve_cmd != last) begin
            cnt <= 0;
            last <= valve_cmd;
            valve_up <= reset;
            valve_down <= 1'b0;
        end else if (cnt < TRAVEL) begin
            cnt <= cnt + 1;
        end else begin
            valve_up <= !last;
            // Misplaced container stops the valve short
            valve_down <= last && !jam;
        end
    end
endmodule : fio_machine
`default_nettype wire

// [testbench/fio_supervisor_asserts.sv]
// Checker for the fill supervisor outputs and strobes.
// Assumes it is bound to fio_supervisor and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fio_supervisor_asserts
    import fio_pkg::*;
#(
    parameter int SETTLE_CYC = FIO_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [FIO_OUT_W-1:0] pin_out,
    input wire fio_wts_t wts,
    input wire logic scale_stable,
    input wire fio_cfg_t cfg,
    input wire logic preact_strobe,
    input wire logic report_strobe
);
    logic [31:0] quiet;
    logic [31:0] next_quiet;
    // Cycles since the valve was last commanded down
    always_comb begin
        next_quiet = quiet;
        if (pin_out[FIO_OUT_VALVE]) begin
            next_quiet = 32'h0000_0000;
        end else if (quiet != 32'hffff_ffff) begin
            next_quiet = quiet + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            quiet <= 32'h0000_0000;
        end else begin
            quiet <= next_quiet;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence lower_start_s;
        $rose(pin_out[FIO_OUT_VALVE]);
    endsequence
    sequence overload_s;
        wts.weight > wts.valve_force;
    endsequence
    reset_clear_a: assert property ($fell(reset) |-> pin_out == 16'h0000 && !preact_strobe)
        else $error("outputs not cleared by reset");
    force_raise_a: assert property (lower_start_s ##[1:4] overload_s |-> ##[1:3] !pin_out[FIO_OUT_VALVE])
        else $error("valve not raised on force trip");
    force_error_a: assert property (lower_start_s ##[1:4] overload_s |-> ##[1:3] pin_out[FIO_OUT_ERROR])
        else $error("no error after force trip");
    feed_valve_a: assert property (|pin_out[FIO_OUT_FINE:FIO_OUT_COARSE] |-> pin_out[FIO_OUT_VALVE])
        else $error("feed with valve up");
    ready_idle_a: assert property (pin_out[FIO_OUT_VALVE] |-> !pin_out[FIO_OUT_READY])
        else $error("ready while filling");
    done_error_a: assert property (!(pin_out[FIO_OUT_DONE] && pin_out[FIO_OUT_ERROR]))
        else $error("done and error together");
    preact_delay_a: assert property (preact_strobe |-> quiet >= 32'(SETTLE_CYC) && cfg.preact_auto ##1 !preact_strobe)
        else $error("preact pulse too early or too long");
    report_settled_a: assert property (report_strobe |-> $past(scale_stable) && cfg.report_en ##1 !report_strobe)
        else $error("report pulse without settled scale");
endmodule : fio_supervisor_asserts
bind fio_supervisor fio_supervisor_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .reset(reset),
    .pin_out(pin_out), .wts(wts), .scale_stable(scale_stable), .cfg(cfg), .preact_strobe(preact_strobe),
    .report_strobe(report_strobe));
`default_nettype wire

// [testbench/fio_supervisor_tb_top.sv]
// Testbench: drives pins, weights and settings, judges outputs and strobes.
// Assumes run enable on input 9, interrupt on input 10, inhibit on input 11, resume on input 16.
// Input 5 counts as failed: the valve down switch comes in on reserve input 8.
// Output 11 mirrors output 5, output 12 shows fill error, output 13 shows busy.
`timescale 1ns/10ps
`default_nettype none
module fio_supervisor_tb_top;
    import fio_pkg::*;
    logic clk, reset, scale_stable, jam, m_up, m_dn, preact_strobe, report_strobe;
    logic [15:0] pins, pin_in, pin_out;
    fio_wts_t wts;
    fio_cfg_t cfg;
    int n_mismatch = 0, tests_run = 0, n_pre = 0, n_rep = 0;
    fio_supervisor #(.SETTLE_CYC(20)) u_dut (.clk(clk), .reset(reset), .pin_in(pin_in), .pin_out(pin_out),
        .wts(wts), .scale_stable(scale_stable), .cfg(cfg), .sel_in_fn(30'h2000_2668), .sel_out_fn(18'h0_0055),
        .preact_strobe(preact_strobe), .report_strobe(report_strobe));
    fio_machine u_mach (.clk(clk), .reset(reset), .valve_cmd(pin_out[FIO_OUT_VALVE]), .jam(jam),
        .valve_up(m_up), .valve_down(m_dn));
    always_comb begin
        pin_in = pins;
        pin_in[FIO_IN_VALVE_UP] = m_up;
        pin_in[FIO_IN_RES2] = m_dn;
    end
    always @(posedge clk) begin
        n_pre += (preact_strobe === 1'b1);
        n_rep += (report_strobe === 1'b1);
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic pin(input int i, input logic v);
        @(posedge clk) pins[i] <= v;
    endtask : pin
    task automatic wait_out(input int i, input logic v, input int lim);
        for (int k = 0; k < lim && pin_out[i] !== v; k++)
            cyc(1);
        check($sformatf("pin_out[%0d]", i), pin_out[i], v);
    endtask : wait_out
    task automatic t_refused;
        pin(8, 1'b0);
        cyc(1100);
        pin(0, 1'b1);
        cyc(1100);
        check("valve", pin_out[FIO_OUT_VALVE], 1'b0);
        check("ready", pin_out[FIO_OUT_READY], 1'b0);
        // Inhibit first, so start never sees a clear window
        pin(10, 1'b1);
        pin(8, 1'b1);
        cyc(1100);
        check("inhibited", pin_out[FIO_OUT_VALVE], 1'b0);
        check("ready", pin_out[FIO_OUT_READY], 1'b1);
        pin(0, 1'b0);
        pin(10, 1'b0);
        cyc(1100);
        check("ready", pin_out[FIO_OUT_READY], 1'b1);
    endtask : t_refused
    task automatic t_fill;
        pin(0, 1'b1);
        cyc(900);
        check("valve early", pin_out[FIO_OUT_VALVE], 1'b0);
        wait_out(FIO_OUT_VALVE, 1'b1, 300);
        check("reserve out", pin_out[FIO_OUT_RES1], 1'b1);
        check("busy out", pin_out[FIO_OUT_RES1 + 2], 1'b1);
        wait_out(FIO_OUT_COARSE, 1'b1, 1200);
        check("catcher", pin_out[FIO_OUT_CATCH], 1'b0);
        pin(9, 1'b0);
        cyc(1100);
        check("feed held", pin_out[FIO_OUT_FINE:FIO_OUT_COARSE], 16'h0000);
        pin(9, 1'b1);
        wait_out(FIO_OUT_COARSE, 1'b1, 1200);
        @(posedge clk) wts.weight <= 24'h00_028A;
        wait_out(FIO_OUT_MEDIUM, 1'b1, 20);
        @(posedge clk) wts.weight <= 24'h00_0352;
        wait_out(FIO_OUT_FINE, 1'b1, 20);
        @(posedge clk) {wts.weight, scale_stable} <= {24'h00_03E9, 1'b0};
        wait_out(FIO_OUT_VALVE, 1'b0, 20);
        cyc(1300);
        check("early strobes", n_pre + n_rep, 16'h0000);
        @(posedge clk) scale_stable <= 1'b1;
        cyc(20);
        check("preact", n_pre, 16'h0001);
        check("report", n_rep, 16'h0001);
        check("done", pin_out[FIO_OUT_DONE], 1'b1);
        pin(0, 1'b0);
        @(posedge clk) wts.weight <= 24'h00_0096;
        cyc(1100);
        check("ready", pin_out[FIO_OUT_READY], 1'b1);
    endtask : t_fill
    task automatic t_trip;
        @(posedge clk) jam <= 1'b1;
        pin(0, 1'b1);
        wait_out(FIO_OUT_VALVE, 1'b1, 1200);
        @(posedge clk) wts.weight <= 24'h00_0190;
        wait_out(FIO_OUT_VALVE, 1'b0, 5);
        wait_out(FIO_OUT_ERROR, 1'b1, 3);
        check("fill error out", pin_out[FIO_OUT_RES2], 1'b1);
        @(posedge clk) {wts.weight, jam} <= {24'h00_0096, 1'b0};
        pin(0, 1'b0);
        cyc(2200);
        check("fault held", pin_out[FIO_OUT_READY], 1'b0);
        pin(15, 1'b1);
        cyc(1100);
        check("resumed", pin_out[FIO_OUT_READY], 1'b1);
        check("error kept", pin_out[FIO_OUT_ERROR], 1'b1);
        pin(15, 1'b0);
        pin(5, 1'b1);
        cyc(1100);
        pin(5, 1'b0);
        cyc(1100);
        check("error", pin_out[FIO_OUT_ERROR], 1'b0);
        check("ready", pin_out[FIO_OUT_READY], 1'b1);
    endtask : t_trip
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        reset = 1'b1;
        pins = 16'h0300;
        jam = 1'b0;
        scale_stable = 1'b1;
        cfg = '{speeds: 2'h3, preact_auto: 1'b1, report_en: 1'b1, in_res_route: 1'b1, in_res_fail: 2'h2,
            out_res_route: 1'b1, out_res_fail: 2'h1, default: '0};
        wts = '{weight: 24'h00_0096, tare_min: 24'h00_0064, tare_max: 24'h00_00C8, valve_force: 24'h00_012C,
            cut_coarse: 24'h00_0258, cut_medium: 24'h00_0320, target: 24'h00_03E8};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        check("reset outputs", pin_out, 16'h0000);
        // Catcher is up whenever the valve is not lowered
        cyc(1);
        check("idle outputs", pin_out, 16'h0080);
        cyc(1100);
        check("ready", pin_out[FIO_OUT_READY], 1'b1);
        t_refused();
        t_fill();
        t_trip();
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule : fio_supervisor_tb_top
`default_nettype wire
